/* File: ptc_pkg.sv */
// constants of the top-level control register bank
// assumes: an 8-bit register port fed by the serial slave front end
package ptc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_TOP_CONTROL_0 = 8'h09;
  localparam logic [7:0] ADDR_TOP_CONTROL_1 = 8'h0a;
  localparam logic [7:0] ADDR_TOP_CONTROL_2 = 8'h0b;
  // top_control_0 fields
  localparam int ILIM_LSB     = 5;
  localparam int SHIP_WAKE    = 4;
  localparam int PD_START     = 3;
  localparam int WDT_CHG_STOP = 2;
  localparam int OUTPUT_GOOD_COMPARE_ENABLE     = 0;
  // top_control_1 fields
  localparam int PREWARN_LSB  = 6;
  localparam int SOURCE_LSB   = 4;
  localparam int OVP_SEL      = 2;
  localparam int UVLO_LSB     = 0;
  // top_control_2 fields
  localparam int INTERNAL_SYSTEM_NODE_UVLO_LSB = 6;
  // reset values and field codes
  localparam logic [7:0] RESET_TOP_CONTROL_0 = 8'h41;
  localparam logic [7:0] RESET_TOP_CONTROL_1 = 8'h89;
  localparam logic [7:0] RESET_TOP_CONTROL_2 = 8'hc0;
  localparam logic [2:0] ILIM_NV_CODE        = 3'h0;
  localparam logic [2:0] ILIM_OFF_CODE       = 3'h7;
  localparam logic [1:0] MODE_ZERO           = 2'h0;
  // supply node source codes
  localparam logic [1:0] SRC_PRIORITY = 2'h0;
  localparam logic [1:0] SRC_BATTERY  = 2'h1;
  localparam logic [1:0] SRC_CHARGER  = 2'h2;
  localparam logic [1:0] SRC_NONE     = 2'h3;
  // timing
  localparam int CLOCK_MHZ          = 200;
  localparam int SYS_RESET_PULSE_NS = 1000;
  localparam int SYS_RESET_CYCLES   =
    (SYS_RESET_PULSE_NS * CLOCK_MHZ + 999) / 1000;
  // rail sequencing states
  typedef enum logic [1:0] {
    RAIL_OFF,
    RAIL_WAIT_KEY,
    RAIL_UP,
    RAIL_LOCKED
  } ptc_rail_t;
endpackage : ptc_pkg

/* File: ptc_sync.sv */
// two-flop synchroniser for pin-level inputs
// assumes: inputs are levels from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module ptc_sync #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] INIT  = 32'h0
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // pin side
  input  wire logic [WIDTH-1:0] async_in,
  // clock side
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds the second and nothing else
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage1   <= INIT[WIDTH-1:0];
      sync_out <= INIT[WIDTH-1:0];
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : ptc_sync
`default_nettype wire

/* File: ptc_pulse.sv */
// fixed-length low pulse generator for the system reset output
// assumes: trigger is a one-cycle pulse on the same clock
`timescale 1ns/100ps
`default_nettype none
module ptc_pulse #(
  parameter int CYCLES = 200
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // control
  input  wire logic trigger,
  // output, low while the pulse runs
  output logic      pulse_n
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count;

  // a new trigger restarts the count so the pulse is never cut short
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count   <= '0;
      pulse_n <= 1'b1;
    end else if (trigger) begin
      count   <= CW'(CYCLES - 1);
      pulse_n <= 1'b0;
    end else if (count != '0) begin
      count   <= count - CW'(1);
    end else begin
      pulse_n <= 1'b1;
    end
  end
endmodule : ptc_pulse
`default_nettype wire

/* File: ptc_top_control.sv */
// top-level control register bank of the power management device
// assumes: a serial slave front end gives byte writes and reads,
// analog blocks take the selection codes, pins arrive unsynchronised
`timescale 1ns/100ps
`default_nettype none
module ptc_top_control #(
  parameter int RESET_PULSE_CYCLES = ptc_pkg::SYS_RESET_CYCLES
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // register port from the serial slave
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  // factory option and pins
  input  wire logic       nv_ilim_low,
  input  wire logic       charger_input_supply,
  input  wire logic       on_key_n,
  // watchdog and mode from neighbouring logic
  input  wire logic       wdt_expired,
  input  wire logic [1:0] chip_mode_request,
  // raw power-good comparator results
  input  wire logic       buck1_compare,
  input  wire logic       buck2_compare,
  input  wire logic       linear1_compare,
  input  wire logic       linear2_compare,
  // charger and limits
  output logic            charge_enable,
  output logic [2:0]      input_current_limit_select,
  output logic            input_current_limit_off,
  output logic            input_overvoltage_select,
  output logic [1:0]      input_undervoltage_select,
  // supply node
  output logic [1:0]      supply_node_prewarn_level,
  output logic [1:0]      supply_node_source_select,
  output logic [1:0]      supply_node_undervoltage_select,
  output logic            use_charger_path,
  output logic            use_battery_path,
  // rail sequencing
  output logic            rails_power_up_start,
  output logic            rails_power_down_start,
  output logic            rails_enabled,
  output logic [1:0]      chip_mode,
  // power good
  output logic            output_good_compare_enable,
  output logic            buck1_output_ok,
  output logic            buck2_output_ok,
  output logic            linear1_output_ok,
  output logic            linear2_output_ok,
  // system reset
  output logic            system_reset_out_n
);
  logic [7:0]         top_control_0;
  logic [7:0]         top_control_1;
  logic [7:0]         top_control_2;
  logic               strap_taken;
  logic               vin_s;
  logic               vin_q;
  logic               key_s;
  logic               key_q;
  logic [3:0]         compare_s;
  logic               vin_plug;
  logic               key_fall;
  logic               wr0;
  logic               wr1;
  logic               wr2;
  logic               pd_request;
  logic               charge_stopped;
  logic               mode_revert;
  ptc_pkg::ptc_rail_t rail_state;
  ptc_pkg::ptc_rail_t next_rail_state;

  // read mux shared by the data path and the hit flag
  function automatic logic [8:0] read_reg(input logic [7:0] a,
                                          input logic [7:0] r0,
                                          input logic [7:0] r1,
                                          input logic [7:0] r2);
    logic [8:0] v;
    v = 9'h000;
    case (a)
      ptc_pkg::ADDR_TOP_CONTROL_0: v = {1'b1, r0};
      ptc_pkg::ADDR_TOP_CONTROL_1: v = {1'b1, r1};
      ptc_pkg::ADDR_TOP_CONTROL_2: v = {1'b1, r2};
      default:                     v = 9'h000;
    endcase
    return v;
  endfunction : read_reg

  // pins and comparators cross into the clock domain
  ptc_sync #(.WIDTH(1), .INIT(32'h0)) u_vin_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (charger_input_supply),
    .sync_out (vin_s)
  );

  ptc_sync #(.WIDTH(1), .INIT(32'h1)) u_key_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (on_key_n),
    .sync_out (key_s)
  );

  ptc_sync #(.WIDTH(4), .INIT(32'h0)) u_cmp_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({buck1_compare, buck2_compare,
                linear1_compare, linear2_compare}),
    .sync_out (compare_s)
  );

  // edge history on synchronised levels only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vin_q <= 1'b0;
      key_q <= 1'b1;
    end else begin
      vin_q <= vin_s;
      key_q <= key_s;
    end
  end

  assign vin_plug = vin_s & ~vin_q;
  assign key_fall = ~key_s & key_q;

  // write decode
  assign wr0 = reg_write & (reg_addr == ptc_pkg::ADDR_TOP_CONTROL_0);
  assign wr1 = reg_write & (reg_addr == ptc_pkg::ADDR_TOP_CONTROL_1);
  assign wr2 = reg_write & (reg_addr == ptc_pkg::ADDR_TOP_CONTROL_2);

  // the option is a level caught once after reset release, never by
  // the asynchronous reset itself
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  // top_control_0; a host write in the strap cycle wins over the option
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      top_control_0 <= ptc_pkg::RESET_TOP_CONTROL_0;
    end else if (wr0) begin
      top_control_0 <= reg_wdata;
    end else if (!strap_taken && nv_ilim_low) begin
      top_control_0[ptc_pkg::ILIM_LSB +: 3] <=
        ptc_pkg::ILIM_NV_CODE;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      top_control_1 <= ptc_pkg::RESET_TOP_CONTROL_1;
    end else if (wr1) begin
      top_control_1 <= reg_wdata;
    end
  end

  // only the upper field is held here; the rest of the third register
  // belongs to the mode block and reads as zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      top_control_2 <= ptc_pkg::RESET_TOP_CONTROL_2;
    end else if (wr2) begin
      top_control_2 <= {reg_wdata[7:6], 6'h00};
    end
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end else if (reg_read) begin
      {reg_hit, reg_rdata} <= read_reg(reg_addr, top_control_0,
                                       top_control_1,
                                       top_control_2);
    end
  end

  // one request per zero-to-one change of the bit; rewriting one while
  // it already reads one starts nothing new
  assign pd_request = wr0 & reg_wdata[ptc_pkg::PD_START]
                    & ~top_control_0[ptc_pkg::PD_START];

  // rail sequencing
  always_comb begin
    next_rail_state = rail_state;
    case (rail_state)
      ptc_pkg::RAIL_OFF: begin
        if (vin_plug) begin
          if (top_control_0[ptc_pkg::SHIP_WAKE]) begin
            next_rail_state = ptc_pkg::RAIL_WAIT_KEY;
          end else begin
            next_rail_state = ptc_pkg::RAIL_UP;
          end
        end else if (key_fall) begin
          next_rail_state = ptc_pkg::RAIL_UP;
        end
      end
      ptc_pkg::RAIL_WAIT_KEY: begin
        if (key_fall) begin
          next_rail_state = ptc_pkg::RAIL_UP;
        end
      end
      ptc_pkg::RAIL_UP: begin
        next_rail_state = ptc_pkg::RAIL_UP;
      end
      ptc_pkg::RAIL_LOCKED: begin
        // a charger plug is ignored here; only the key wakes the rails
        if (key_fall) begin
          next_rail_state = ptc_pkg::RAIL_UP;
        end
      end
      default: begin
        next_rail_state = ptc_pkg::RAIL_OFF;
      end
    endcase
    if (pd_request) begin
      next_rail_state = ptc_pkg::RAIL_LOCKED;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rail_state <= ptc_pkg::RAIL_OFF;
    end else begin
      rail_state <= next_rail_state;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rails_power_up_start   <= 1'b0;
      rails_power_down_start <= 1'b0;
    end else begin
      rails_power_up_start   <= (next_rail_state == ptc_pkg::RAIL_UP)
                              && (rail_state != ptc_pkg::RAIL_UP);
      rails_power_down_start <= pd_request;
    end
  end

  assign rails_enabled = (rail_state == ptc_pkg::RAIL_UP);

  // watchdog: charge stop follows the bit; the set wins over the clear
  // by a charger unplug in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      charge_stopped <= 1'b0;
    end else if (wdt_expired && top_control_0[ptc_pkg::WDT_CHG_STOP]) begin
      charge_stopped <= 1'b1;
    end else if (!vin_s) begin
      charge_stopped <= 1'b0;
    end
  end

  // charging in every rail state once the charger is present
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      charge_enable <= 1'b0;
    end else begin
      charge_enable <= vin_s & ~charge_stopped
                     & ~(wdt_expired
                         & top_control_0[ptc_pkg::WDT_CHG_STOP]);
    end
  end

  // mode 0 is held after the watchdog until the host asks for mode 0
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_revert <= 1'b0;
      chip_mode   <= ptc_pkg::MODE_ZERO;
    end else begin
      if (wdt_expired) begin
        mode_revert <= 1'b1;
      end else if (chip_mode_request == ptc_pkg::MODE_ZERO) begin
        mode_revert <= 1'b0;
      end
      chip_mode <= (wdt_expired || mode_revert) ? ptc_pkg::MODE_ZERO
                                                : chip_mode_request;
    end
  end

  ptc_pulse #(.CYCLES(RESET_PULSE_CYCLES)) u_sys_reset (
    .clock   (clock),
    .rstn    (rstn),
    .trigger (wdt_expired),
    .pulse_n (system_reset_out_n)
  );

  // power-good status, forced low while the comparators are off
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {buck1_output_ok, buck2_output_ok,
       linear1_output_ok, linear2_output_ok} <= 4'h0;
    end else if (!top_control_0[ptc_pkg::OUTPUT_GOOD_COMPARE_ENABLE]) begin
      {buck1_output_ok, buck2_output_ok,
       linear1_output_ok, linear2_output_ok} <= 4'h0;
    end else begin
      {buck1_output_ok, buck2_output_ok,
       linear1_output_ok, linear2_output_ok} <= compare_s;
    end
  end

  // field outputs, straight from the registers
  assign input_current_limit_select =
    top_control_0[ptc_pkg::ILIM_LSB +: 3];
  assign input_current_limit_off =
    (input_current_limit_select == ptc_pkg::ILIM_OFF_CODE);
  assign output_good_compare_enable =
    top_control_0[ptc_pkg::OUTPUT_GOOD_COMPARE_ENABLE];
  assign supply_node_prewarn_level =
    top_control_1[ptc_pkg::PREWARN_LSB +: 2];
  assign supply_node_source_select =
    top_control_1[ptc_pkg::SOURCE_LSB +: 2];
  assign input_overvoltage_select =
    top_control_1[ptc_pkg::OVP_SEL];
  assign input_undervoltage_select =
    top_control_1[ptc_pkg::UVLO_LSB +: 2];
  assign supply_node_undervoltage_select =
    top_control_2[ptc_pkg::INTERNAL_SYSTEM_NODE_UVLO_LSB +: 2];

  // supply node path: charger beats battery in the priority code;
  // the test code opens both switches
  always_comb begin
    use_charger_path = 1'b0;
    use_battery_path = 1'b0;
    case (supply_node_source_select)
      ptc_pkg::SRC_PRIORITY: begin
        use_charger_path = vin_s;
        use_battery_path = ~vin_s;
      end
      ptc_pkg::SRC_BATTERY: begin
        use_battery_path = 1'b1;
      end
      ptc_pkg::SRC_CHARGER: begin
        use_charger_path = 1'b1;
      end
      ptc_pkg::SRC_NONE: begin
        use_charger_path = 1'b0;
      end
      default: begin
        use_charger_path = 1'b0;
      end
    endcase
  end
endmodule : ptc_top_control
`default_nettype wire

/* File: ptc_host.sv */
// host model: register accesses as the serial slave passes them on
// assumes: the bench clock; each access starts at a falling edge
`timescale 1ns/100ps
`default_nettype none
module ptc_host (
  // clock
  input  wire logic       clock,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_write,
  output logic      [7:0] reg_wdata,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit
);
  initial begin
    reg_addr  = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read  = 1'b0;
  end
  // single bytes only; reserved bit values are the caller's duty
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    reg_addr  = addr;
    reg_wdata = data;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_wdata = ~data;
  endtask : write_reg
  // read data is registered at the taking edge, valid right after it
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic hit);
    @(negedge clock);
    reg_addr = addr;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    data     = reg_rdata;
    hit      = reg_hit;
  endtask : read_reg
endmodule : ptc_host
`default_nettype wire

/* File: ptc_top_control_monitor.sv */
// checker of the top-level control register bank at its ports
// assumes: bound into ptc_top_control, a single clock domain
`timescale 1ns/100ps
`default_nettype none
module ptc_top_control_monitor #(
  parameter int RESET_PULSE_CYCLES = ptc_pkg::SYS_RESET_CYCLES
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_read,
  input wire logic       reg_hit,
  input wire logic       wdt_expired,
  // register fields
  input wire logic [2:0] input_current_limit_select,
  input wire logic       input_current_limit_off,
  input wire logic       input_overvoltage_select,
  input wire logic [1:0] input_undervoltage_select,
  input wire logic [1:0] supply_node_prewarn_level,
  input wire logic [1:0] supply_node_source_select,
  input wire logic [1:0] supply_node_undervoltage_select,
  input wire logic       output_good_compare_enable,
  // control results
  input wire logic       charge_enable,
  input wire logic       rails_power_down_start,
  input wire logic       rails_enabled,
  input wire logic [1:0] chip_mode,
  input wire logic       buck1_output_ok,
  input wire logic       buck2_output_ok,
  input wire logic       linear1_output_ok,
  input wire logic       linear2_output_ok,
  input wire logic       system_reset_out_n
);
  // action bits shadowed from the strobe, since they are not at the ports
  logic       pd_bit;
  logic       stop_bit;
  logic [7:0] last_wdata;
  logic       last_mapped;
  logic       w09;
  logic       pd_req;
  logic       any_ok;
  int         low_cnt;
  assign w09    = reg_write && reg_addr == 8'h09;
  assign pd_req = w09 && reg_wdata[3] && !pd_bit;
  assign any_ok = buck1_output_ok | buck2_output_ok | linear1_output_ok
                | linear2_output_ok;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pd_bit   <= 1'b0;
      stop_bit <= 1'b0;
    end else if (w09) begin
      pd_bit   <= reg_wdata[3];
      stop_bit <= reg_wdata[2];
    end
  end
  always_ff @(posedge clock) begin
    last_wdata  <= reg_wdata;
    last_mapped <= reg_addr inside {8'h09, 8'h0a, 8'h0b};
  end
  // a retrigger restarts the count, as it restarts the pulse
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) low_cnt <= 0;
    else if (wdt_expired || system_reset_out_n) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_ILIM_OFF: assert property (
    input_current_limit_off == (input_current_limit_select == 3'h7))
    else $error("limit off flag disagrees with code");
  AST_CTL0_WRITE: assert property (w09 |=>
    {input_current_limit_select, output_good_compare_enable}
      == {last_wdata[7:5], last_wdata[0]})
    else $error("control 0 write not applied");
  AST_CTL1_WRITE: assert property (
    reg_write && reg_addr == 8'h0a |=>
      {supply_node_prewarn_level, supply_node_source_select,
       input_overvoltage_select, input_undervoltage_select}
        == {last_wdata[7:4], last_wdata[2:0]})
    else $error("control 1 write not applied");
  AST_CTL2_WRITE: assert property (
    reg_write && reg_addr == 8'h0b |=>
      supply_node_undervoltage_select == last_wdata[7:6])
    else $error("control 2 write not applied");
  AST_READ_HIT: assert property (
    reg_read |=> reg_hit == last_mapped)
    else $error("read hit flag wrong");
  AST_PD_START: assert property (
    pd_req |=> rails_power_down_start && !rails_enabled)
    else $error("power-down request missing");
  AST_PD_ONLY: assert property (
    rails_power_down_start |-> $past(pd_req))
    else $error("power-down request without a rising bit");
  AST_WDT_ACT: assert property (
    wdt_expired |=> !system_reset_out_n && chip_mode == 2'h0)
    else $error("watchdog reaction missing");
  AST_CHG_STOP: assert property (
    wdt_expired && stop_bit |=> !charge_enable)
    else $error("charging not stopped on watchdog");
  AST_PULSE_LEN: assert property (
    $rose(system_reset_out_n) |-> low_cnt == RESET_PULSE_CYCLES)
    else $error("system reset pulse length wrong");
  AST_PGOOD_OFF: assert property (
    !output_good_compare_enable |=> !any_ok)
    else $error("output ok set with comparators off");
endmodule : ptc_top_control_monitor
bind ptc_top_control ptc_top_control_monitor #(
  .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)
) ptc_top_control_monitor_inst (
  .clock, .rstn, .reg_addr, .reg_write, .reg_wdata, .reg_read, .reg_hit,
  .wdt_expired, .input_current_limit_select, .input_current_limit_off,
  .input_overvoltage_select, .input_undervoltage_select,
  .supply_node_prewarn_level, .supply_node_source_select,
  .supply_node_undervoltage_select, .output_good_compare_enable,
  .charge_enable, .rails_power_down_start, .rails_enabled, .chip_mode,
  .buck1_output_ok, .buck2_output_ok, .linear1_output_ok,
  .linear2_output_ok, .system_reset_out_n
);
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the top-level control register bank
// assumes: ptc_host drives the register port, the bench drives the pins
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int PULSE = 4;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd, a, d;
  logic        reg_write, reg_read, reg_hit, hit, up;
  logic        nv_ilim_low = 1'b0;
  logic        charger_input_supply = 1'b0;
  logic        on_key_n = 1'b1;
  logic        wdt_expired = 1'b0;
  logic [1:0]  chip_mode_request = 2'h2;
  logic [3:0]  cmp = 4'h0;
  logic [3:0]  ok, f09, wd;
  logic [2:0]  input_current_limit_select;
  logic [1:0]  input_undervoltage_select, supply_node_prewarn_level;
  logic [1:0]  supply_node_source_select, supply_node_undervoltage_select;
  logic [1:0]  chip_mode, paths;
  logic [7:0]  f0a;
  logic        charge_enable, input_current_limit_off;
  logic        input_overvoltage_select, use_charger_path, use_battery_path;
  logic        rails_power_up_start, rails_power_down_start, rails_enabled;
  logic        output_good_compare_enable, system_reset_out_n;
  int          err_count = 0;
  int          checked = 0;
  int unsigned seed;
  assign f09   = {input_current_limit_select, output_good_compare_enable};
  assign f0a   = {supply_node_prewarn_level, supply_node_source_select,
                  1'b1, input_overvoltage_select, input_undervoltage_select};
  assign wd    = {system_reset_out_n, chip_mode, charge_enable};
  assign paths = {use_charger_path, use_battery_path};
  always #2.5 clock = ~clock;
  ptc_host ptc_host_inst (
    .clock, .reg_addr, .reg_write, .reg_wdata, .reg_read, .reg_rdata,
    .reg_hit
  );
  ptc_top_control #(.RESET_PULSE_CYCLES(PULSE)) ptc_top_control_inst (
    .clock, .rstn, .reg_addr, .reg_write, .reg_wdata, .reg_read, .reg_rdata,
    .reg_hit, .nv_ilim_low, .charger_input_supply, .on_key_n, .wdt_expired,
    .chip_mode_request, .buck1_compare(cmp[0]), .buck2_compare(cmp[1]),
    .linear1_compare(cmp[2]), .linear2_compare(cmp[3]), .charge_enable,
    .input_current_limit_select, .input_current_limit_off,
    .input_overvoltage_select, .input_undervoltage_select,
    .supply_node_prewarn_level, .supply_node_source_select,
    .supply_node_undervoltage_select, .use_charger_path, .use_battery_path,
    .rails_power_up_start, .rails_power_down_start, .rails_enabled,
    .chip_mode, .output_good_compare_enable, .buck1_output_ok(ok[0]),
    .buck2_output_ok(ok[1]), .linear1_output_ok(ok[2]),
    .linear2_output_ok(ok[3]), .system_reset_out_n
  );
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // pins are released during reset so no stale charger edge wakes rails
  task automatic do_reset(input logic nv);
    @(negedge clock);
    rstn = 1'b0;
    nv_ilim_low = nv;
    charger_input_supply = 1'b0;
    on_key_n = 1'b1;
    repeat (20) @(negedge clock);
    rstn = 1'b1;
  endtask : do_reset
  task automatic rd_chk(input logic [7:0] addr, input logic [8:0] exp);
    ptc_host_inst.read_reg(addr, rd, hit);
    check({hit, rd}, exp);
  endtask : rd_chk
  // bounded wait for a power-up pulse; a missing one ends the run
  task automatic await_up(input logic must);
    up = 1'b0;
    for (int i = 0; i < 12 && !up; i++) begin
      @(negedge clock);
      up = rails_power_up_start;
    end
    check({8'h0, up}, {8'h0, must});
    if (must && up !== 1'b1) wrap_up();
  endtask : await_up
  function automatic logic [8:0] exp_rd(input logic [7:0] ad,
                                        input logic [7:0] dt);
    case (ad)
      8'h09, 8'h0a: exp_rd = {1'b1, dt};
      8'h0b: exp_rd = {1'b1, dt & 8'hc0};
      default: exp_rd = 9'h000;
    endcase
  endfunction : exp_rd
  function automatic logic [8:0] src_exp(input int c);
    return {7'h0, c == 0 || c == 2, c == 1};
  endfunction : src_exp
  initial begin
    seed = $urandom(67360);
    do_reset(1'b0);
    rd_chk(8'h09, 9'h141);
    rd_chk(8'h0a, 9'h189);
    rd_chk(8'h0b, 9'h1c0);
    check({5'h0, f09}, 9'h005);
    check({1'b0, f0a}, 9'h089);
    check({7'h0, supply_node_undervoltage_select}, 9'h003);
    do_reset(1'b1);
    rd_chk(8'h09, 9'h101);
    do_reset(1'b0);
    for (int c = 0; c < 8; c++) begin
      ptc_host_inst.write_reg(8'h09, {c[2:0], 5'h01});
      check({5'h0, f09}, {5'h0, c[2:0], 1'b1});
      check({8'h0, input_current_limit_off}, {8'h0, c == 7});
    end
    // random traffic, with now and then an unmapped address
    for (int i = 0; i < 24; i++) begin
      a = (i % 6 == 5) ? 8'($urandom_range(255, 16)) : 8'h09 + 8'(i % 3);
      d = 8'($urandom);
      if (a == 8'h09) d = d & 8'hf5;
      if (a == 8'h0a) d = d | 8'h08;
      ptc_host_inst.write_reg(a, d);
      if (a == 8'h0a) check({1'b0, f0a}, {1'b0, d});
      rd_chk(a, exp_rd(a, d));
    end
    do_reset(1'b0);
    charger_input_supply = 1'b1;
    await_up(1'b1);
    check({7'h0, charge_enable, rails_enabled}, 9'h003);
    for (int c = 0; c < 4; c++) begin
      ptc_host_inst.write_reg(8'h0a, {2'h2, c[1:0], 4'h9});
      check({7'h0, paths}, src_exp(c));
    end
    cmp = 4'hf;
    repeat (4) @(negedge clock);
    check({5'h0, ok}, 9'h00f);
    ptc_host_inst.write_reg(8'h09, 8'h40);
    repeat (2) @(negedge clock);
    check({5'h0, ok}, 9'h000);
    ptc_host_inst.write_reg(8'h09, 8'h49);
    check({7'h0, rails_power_down_start, rails_enabled}, 9'h002);
    ptc_host_inst.write_reg(8'h09, 8'h49);
    check({8'h0, rails_power_down_start}, 9'h000);
    charger_input_supply = 1'b0;
    repeat (6) @(negedge clock);
    charger_input_supply = 1'b1;
    await_up(1'b0);
    on_key_n = 1'b0;
    await_up(1'b1);
    on_key_n = 1'b1;
    ptc_host_inst.write_reg(8'h09, 8'h41);
    check({8'h0, rails_power_down_start}, 9'h000);
    do_reset(1'b0);
    ptc_host_inst.write_reg(8'h09, 8'h51);
    charger_input_supply = 1'b1;
    await_up(1'b0);
    check({8'h0, charge_enable}, 9'h001);
    on_key_n = 1'b0;
    await_up(1'b1);
    on_key_n = 1'b1;
    for (int s = 0; s < 2; s++) begin
      ptc_host_inst.write_reg(8'h09, {5'h0a, s[0], 2'h1});
      check({7'h0, chip_mode}, 9'h002);
      wdt_expired = 1'b1;
      @(negedge clock);
      wdt_expired = 1'b0;
      check({5'h0, wd}, {8'h0, ~s[0]});
      repeat (PULSE - 1) @(negedge clock);
      check({8'h0, system_reset_out_n}, 9'h000);
      @(negedge clock);
      check({8'h0, system_reset_out_n}, 9'h001);
      chip_mode_request = 2'h0;
      repeat (2) @(negedge clock);
      chip_mode_request = 2'h2;
      repeat (2) @(negedge clock);
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
